/* dcf_pkg.sv */
package dcf_pkg;

  // Word width and the two documented depths.
  localparam int DCF_WIDTH = 18;
  localparam int DCF_DEPTH_SMALL = 32768;
  localparam int DCF_DEPTH_LARGE = 65536;

  // Register stages on the flag outputs and on the pointer exchange.
  localparam int DCF_SYNC_STAGES = 2;
  localparam int DCF_FLAG_STAGES = 2;
  localparam int DCF_READY_STAGES = 3;

  // Default offsets chosen by the load-select level at reset.
  localparam logic [15:0] DCF_OFS_SERIAL_DEF = 16'h03FF;
  localparam logic [15:0] DCF_OFS_PARALLEL_DEF = 16'h007F;

  // Flag levels while reset is held.
  localparam logic DCF_EMPTY_RST = 1'b0;
  localparam logic DCF_FULL_RST = 1'b1;
  localparam logic DCF_OREADY_RST = 1'b1;
  localparam logic DCF_ISPACE_RST = 1'b0;
  localparam logic DCF_AEMPTY_RST = 1'b0;
  localparam logic DCF_HALF_RST = 1'b1;
  localparam logic DCF_AFULL_RST = 1'b1;

  // Configuration caught while reset is held.
  typedef struct packed {
    logic fwft;
    logic serial_load;
  } dcf_mode_s;

endpackage

/* dcf_flag_top.sv */
// Behaviour
// RL1: Mode pin level at reset picks timing mode.
// RL2: Standard mode presents words only on read enable.
// RL3: Fall-through shows first word after three edges.
// RL4: Write enable low stores data each clock edge.
// RL5: Standard empty flag rises after first write.
// RL6: Standard almost-empty rises at offset plus one.
// RL7: Standard half-full falls at half depth plus one.
// RL8: Standard almost-full falls at depth minus offset.
// RL9: Standard full flag falls at depth, blocks writes.
// RL10: Standard almost-empty falls back at empty offset.
// RL11: Standard empty falls after last read; reads ignored.
// RL12: Standard empty and full pass two stages.
// RL13: Fall-through output-ready falls after first write.
// RL14: Fall-through almost-empty rises at offset plus two.
// RL15: Fall-through half-full falls at half plus two.
// RL16: Fall-through almost-full falls at depth+1 minus offset.
// RL17: Fall-through input-space rises at depth plus one.
// RL18: Fall-through first read frees space; almost-empty at n+1.
// RL19: Fall-through output-ready rises when drained; reads ignored.
// RL20: Output-ready three stages, input-space two stages.
// RL21: Load-select at reset picks method and defaults.
// RL22: Offsets read back only over the parallel path.
// RL23: Eighteen-bit words; pointers exchanged through synchronisers.
// RL24: Refused writes store nothing, pointer unchanged.
`timescale 1ns/100ps

module dcf_buf #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 8,
  parameter int SYNC = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  // Words held, seen without synchroniser lag
  output logic [$clog2(DEPTH):0] level
);

  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH || SYNC < 2) begin : g_chk
    $error("dcf_buf: DEPTH must be a power of two and SYNC at least 2");
  end

  if (WIDTH < 1) begin : g_chk_width
    $error("dcf_buf: WIDTH must be at least 1");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0] wptr;
    logic [AW:0] rptr;
    logic [SYNC-1:0][AW:0] wsync;
    logic [SYNC-1:0][AW:0] rsync;
  } dcf_buf_state_s;

  dcf_buf_state_s s_q;
  dcf_buf_state_s s_d;

  // Each side judges space or data from the other side's pointer as seen
  // through its synchroniser, so both flags are conservative.
  always_comb begin
    in_ready = (s_q.wptr ^ s_q.rsync[SYNC-1]) != {1'b1, {AW{1'b0}}};
    out_valid = s_q.wsync[SYNC-1] != s_q.rptr;
    out_data = s_q.mem[s_q.rptr[AW-1:0]];
    level = s_q.wptr - s_q.rptr;
  end

  always_comb begin
    s_d = s_q;
    s_d.wsync = {s_q.wsync[SYNC-2:0], s_q.wptr}; // RL23
    s_d.rsync = {s_q.rsync[SYNC-2:0], s_q.rptr}; // RL23
    if (in_valid && in_ready) begin
      s_d.mem[s_q.wptr[AW-1:0]] = in_data;
      s_d.wptr = s_q.wptr + 1'b1;
    end
    if (out_valid && out_ready) begin
      s_d.rptr = s_q.rptr + 1'b1;
    end
    if (!nrst) begin
      s_d.wptr = '0;
      s_d.rptr = '0;
      s_d.wsync = '0;
      s_d.rsync = '0;
    end
  end

  always_ff @(posedge clk) begin
    s_q <= s_d;
  end

endmodule

module dcf_flag_top import dcf_pkg::*; #(
  parameter int DEPTH = DCF_DEPTH_SMALL
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Configuration straps, caught while reset is held
  input wire logic mode_select_pin,
  input wire logic offset_load_select,
  // Write side
  input wire logic write_enable_n,
  input wire logic [DCF_WIDTH-1:0] data_in_bus,
  // Read side
  input wire logic read_enable_n,
  output logic [DCF_WIDTH-1:0] data_out_bus,
  // Standard mode flags
  output logic empty_indicator_n,
  output logic full_indicator_n,
  // Fall-through mode flags
  output logic output_ready_n,
  output logic input_space_indicator_n,
  // Flags of both modes
  output logic almost_empty_indicator_n,
  output logic half_full_indicator_n,
  output logic almost_full_indicator_n
);

  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;
  localparam logic [CW-1:0] HALF = CW'(DEPTH / 2);
  localparam logic [CW-1:0] FULLCNT = CW'(DEPTH);

  if ((1 << AW) != DEPTH) begin : g_chk_pow
    $error("dcf_flag_top: DEPTH must be a power of two");
  end

  if (AW < 11 || AW > 16) begin : g_chk
    $error("dcf_flag_top: DEPTH must be a power of two from 2048 to 65536");
  end

  // The output taps below index the last stage of each flag pipeline.
  if (DCF_FLAG_STAGES != 2 || DCF_READY_STAGES != 3) begin : g_chk_stages
    $error("dcf_flag_top: flag pipelines must have two and three stages");
  end

  typedef struct packed {
    dcf_mode_s mode;
    logic [AW-1:0] empty_off;
    logic [AW-1:0] full_off;
    logic ofs_wr_sel;
    logic ofs_rd_sel;
    logic [DCF_WIDTH-1:0] dout;
    logic ovalid;
    logic [DCF_FLAG_STAGES-1:0] ef_pipe;
    logic [DCF_FLAG_STAGES-1:0] ff_pipe;
    logic [DCF_READY_STAGES-1:0] or_pipe;
    logic [DCF_FLAG_STAGES-1:0] ir_pipe;
    logic pae_n;
    logic hf_n;
    logic paf_n;
  } dcf_state_s;

  dcf_state_s s_q;
  dcf_state_s s_d;

  logic buf_in_valid;
  logic buf_in_ready;
  logic buf_out_valid;
  logic buf_out_ready;
  logic [DCF_WIDTH-1:0] buf_out_data;
  logic [CW-1:0] buf_level;

  // Fall-through counts include the output register, so every threshold
  // sits one word higher; removing that word lets both modes share compares.
  function automatic logic [CW-1:0] eff_count(input logic fwft, input logic [CW-1:0] lvl,
                                               input logic held);
    logic [CW-1:0] tot;
    tot = lvl + CW'(held);
    if (fwft && tot != '0) begin
      eff_count = tot - 1'b1;
    end else begin
      eff_count = tot;
    end
  endfunction

  function automatic logic [AW-1:0] ofs_default(input logic serial);
    ofs_default = serial ? AW'(DCF_OFS_SERIAL_DEF) : AW'(DCF_OFS_PARALLEL_DEF);
  endfunction

  // Memory access needs the load select high; offset access needs it low.
  function automatic logic mem_req(input logic en_n, input logic ld);
    mem_req = !en_n && ld;
  endfunction

  function automatic logic ofs_req(input logic en_n, input logic ld);
    ofs_req = !en_n && !ld;
  endfunction

  function automatic logic [DCF_FLAG_STAGES-1:0] flag_shift(
    input logic [DCF_FLAG_STAGES-1:0] pipe, input logic flag);
    flag_shift = {pipe[DCF_FLAG_STAGES-2:0], flag};
  endfunction

  dcf_buf #(
    .WIDTH(DCF_WIDTH),
    .DEPTH(DEPTH),
    .SYNC(DCF_SYNC_STAGES)
  ) u_buf (
    .clk(clk),
    .nrst(nrst),
    .in_valid(buf_in_valid),
    .in_ready(buf_in_ready),
    .in_data(data_in_bus),
    .out_valid(buf_out_valid),
    .out_ready(buf_out_ready),
    .out_data(buf_out_data),
    .level(buf_level)
  );

  logic std_read;
  logic ft_read;
  logic ft_pop;
  logic [CW-1:0] cnt;
  logic mem_wr;
  logic mem_rd;
  logic ofs_wr;
  logic ofs_rd;

  always_comb begin
    mem_wr = mem_req(write_enable_n, offset_load_select);
    mem_rd = mem_req(read_enable_n, offset_load_select);
    ofs_wr = ofs_req(write_enable_n, offset_load_select);
    ofs_rd = ofs_req(read_enable_n, offset_load_select);
    // A write is taken only when the visible flag shows space.
    if (s_q.mode.fwft) begin
      buf_in_valid = mem_wr && !s_q.ir_pipe[1]; // RL4 RL17 RL24
    end else begin
      buf_in_valid = mem_wr && s_q.ff_pipe[1]; // RL4 RL9 RL24
    end
    // Standard reads are refused while the empty flag shows empty.
    std_read = !s_q.mode.fwft && mem_rd
               && s_q.ef_pipe[1] && buf_out_valid; // RL11
    // Fall-through reads consume the output register only while it is shown.
    ft_read = s_q.mode.fwft && mem_rd
              && !s_q.or_pipe[2] && s_q.ovalid; // RL19
    // The output register refills itself without any read request.
    ft_pop = s_q.mode.fwft && buf_out_valid && (!s_q.ovalid || ft_read); // RL3
    buf_out_ready = std_read || ft_pop;
    cnt = eff_count(s_q.mode.fwft, buf_level, s_q.ovalid);
  end

  always_comb begin
    s_d = s_q;

    // Data path.
    if (std_read) begin
      s_d.dout = buf_out_data; // RL2
    end
    if (ft_pop) begin
      s_d.dout = buf_out_data; // RL3
      s_d.ovalid = 1'b1;
    end else if (ft_read) begin
      s_d.ovalid = 1'b0; // RL19
    end

    // Offset access with load-select low.
    if (ofs_wr && !s_q.mode.serial_load) begin
      if (s_q.ofs_wr_sel) begin
        s_d.full_off = data_in_bus[AW-1:0];
      end else begin
        s_d.empty_off = data_in_bus[AW-1:0];
      end
      s_d.ofs_wr_sel = !s_q.ofs_wr_sel;
    end
    if (ofs_rd) begin
      // Readback shares the data outputs whatever loading method is in use.
      if (s_q.ofs_rd_sel) begin
        s_d.dout = DCF_WIDTH'(s_q.full_off); // RL22
      end else begin
        s_d.dout = DCF_WIDTH'(s_q.empty_off); // RL22
      end
      s_d.ofs_rd_sel = !s_q.ofs_rd_sel;
    end

    // Flag stages; the flag of the unused mode stays at its reset level.
    if (s_q.mode.fwft) begin
      s_d.ef_pipe = {DCF_FLAG_STAGES{DCF_EMPTY_RST}};
      s_d.ff_pipe = {DCF_FLAG_STAGES{DCF_FULL_RST}};
      s_d.or_pipe = {s_q.or_pipe[1:0], !s_q.ovalid}; // RL13 RL20
      // The space flag trails a read by the pointer synchroniser and two stages.
      s_d.ir_pipe = flag_shift(s_q.ir_pipe, !buf_in_ready); // RL17 RL18 RL20
    end else begin
      s_d.ef_pipe = flag_shift(s_q.ef_pipe, buf_out_valid); // RL5 RL11 RL12
      s_d.ff_pipe = flag_shift(s_q.ff_pipe, buf_in_ready); // RL9 RL12
      s_d.or_pipe = {DCF_READY_STAGES{DCF_OREADY_RST}};
      s_d.ir_pipe = {DCF_FLAG_STAGES{DCF_ISPACE_RST}};
    end

    // Partial flags on the mode-adjusted count.
    s_d.pae_n = cnt > CW'(s_q.empty_off); // RL6 RL10 RL14 RL18
    s_d.hf_n = !(cnt > HALF); // RL7 RL15
    s_d.paf_n = !(cnt >= FULLCNT - CW'(s_q.full_off)); // RL8 RL16

    if (!nrst) begin
      // Straps are caught on every reset edge, so the last one wins.
      s_d.mode.fwft = mode_select_pin; // RL1
      s_d.mode.serial_load = offset_load_select; // RL21
      s_d.empty_off = ofs_default(offset_load_select); // RL21
      s_d.full_off = ofs_default(offset_load_select); // RL21
      s_d.ofs_wr_sel = 1'b0;
      s_d.ofs_rd_sel = 1'b0;
      s_d.dout = '0;
      s_d.ovalid = 1'b0;
      s_d.ef_pipe = {DCF_FLAG_STAGES{DCF_EMPTY_RST}};
      s_d.ff_pipe = {DCF_FLAG_STAGES{DCF_FULL_RST}};
      s_d.or_pipe = {DCF_READY_STAGES{DCF_OREADY_RST}};
      s_d.ir_pipe = {DCF_FLAG_STAGES{DCF_ISPACE_RST}};
      s_d.pae_n = DCF_AEMPTY_RST;
      s_d.hf_n = DCF_HALF_RST;
      s_d.paf_n = DCF_AFULL_RST;
    end
  end

  always_ff @(posedge clk) begin
    s_q <= s_d;
  end

  // Every output is a register bit.
  assign data_out_bus = s_q.dout;
  assign empty_indicator_n = s_q.ef_pipe[1];
  assign full_indicator_n = s_q.ff_pipe[1];
  assign output_ready_n = s_q.or_pipe[2];
  assign input_space_indicator_n = s_q.ir_pipe[1];
  assign almost_empty_indicator_n = s_q.pae_n;
  assign half_full_indicator_n = s_q.hf_n;
  assign almost_full_indicator_n = s_q.paf_n;

endmodule

/* dcf_flag_checker.sv */
`timescale 1ns/100ps
module dcf_flag_checker import dcf_pkg::*; #(
  parameter int DEPTH = DCF_DEPTH_SMALL
) (
  // Clock and straps
  input wire logic clk,
  input wire logic nrst,
  input wire logic mode_select_pin,
  input wire logic offset_load_select,
  // Requests
  input wire logic write_enable_n,
  input wire logic read_enable_n,
  // Outputs
  input wire logic [DCF_WIDTH-1:0] data_out_bus,
  input wire logic empty_indicator_n,
  input wire logic full_indicator_n,
  input wire logic output_ready_n,
  input wire logic input_space_indicator_n,
  input wire logic almost_empty_indicator_n,
  input wire logic half_full_indicator_n,
  input wire logic almost_full_indicator_n
);
  logic ft_q;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ft_q <= mode_select_pin;
    end
  end
  default clocking @(posedge clk);
  endclocking
  default disable iff (!nrst);
  std_idle_a: assert property (!ft_q |-> output_ready_n && !input_space_indicator_n)
    else $error("ready flags active in standard mode");
  ft_idle_a: assert property (ft_q |-> !empty_indicator_n && full_indicator_n)
    else $error("empty or full flag active in fall-through mode");
  empty_read_a: assert property (!ft_q && !empty_indicator_n && !read_enable_n &&
    offset_load_select |=> $stable(data_out_bus)) else $error("read taken while empty");
  first_flag_a: assert property (!ft_q && !empty_indicator_n && !write_enable_n &&
    offset_load_select |-> ##[1:6] empty_indicator_n) else $error("empty flag stuck");
  ft_first_a: assert property (ft_q && output_ready_n && !write_enable_n &&
    offset_load_select && !input_space_indicator_n |-> ##[1:8] !output_ready_n)
    else $error("output ready never went low");
  full_af_a: assert property (!ft_q && !full_indicator_n |->
    !almost_full_indicator_n && !half_full_indicator_n) else $error("full without partials");
  space_af_a: assert property (ft_q && input_space_indicator_n |->
    !almost_full_indicator_n && !half_full_indicator_n) else $error("no space without partials");
  empty_ae_a: assert property (!ft_q && !empty_indicator_n |-> !almost_empty_indicator_n)
    else $error("empty but almost empty high");
  half_ae_a: assert property (!half_full_indicator_n |-> almost_empty_indicator_n)
    else $error("half full but almost empty low");
endmodule
bind dcf_flag_top dcf_flag_checker #(.DEPTH(DEPTH)) i_dcf_flag_checker (.clk(clk), .nrst(nrst),
  .mode_select_pin(mode_select_pin), .offset_load_select(offset_load_select),
  .write_enable_n(write_enable_n), .read_enable_n(read_enable_n), .data_out_bus(data_out_bus),
  .empty_indicator_n(empty_indicator_n), .full_indicator_n(full_indicator_n),
  .output_ready_n(output_ready_n), .input_space_indicator_n(input_space_indicator_n),
  .almost_empty_indicator_n(almost_empty_indicator_n),
  .half_full_indicator_n(half_full_indicator_n),
  .almost_full_indicator_n(almost_full_indicator_n));

/* dcf_reader_model.sv */
`timescale 1ns/100ps
module dcf_reader_model (
  // Clock and command
  input wire logic clk,
  input wire logic load,
  input wire logic [16:0] quota,
  input wire logic slow,
  // Device side
  input wire logic ld,
  input wire logic word_ready,
  output logic read_enable_n,
  output logic done
);
  int left = 0;
  int taken;
  initial read_enable_n = 1'b1;
  // Offset reads always count; memory reads only while a word is shown.
  always @(posedge clk) begin
    taken = (!read_enable_n && (!ld || word_ready)) ? 1 : 0;
    left = load ? int'(quota) : left - taken;
    read_enable_n <= !(left > 0 && !(slow && $urandom_range(1) == 1));
  end
  assign done = (left == 0);
endmodule

/* dcf_flag_top_tb_top.sv */
`timescale 1ns/100ps
module dcf_flag_top_tb_top import dcf_pkg::*;;
  localparam int D = 4096;
  logic clk = 1'b0, nrst = 1'b0, mode_select_pin = 1'b0, offset_load_select = 1'b0;
  logic write_enable_n = 1'b1, read_enable_n, load = 1'b0, slow = 1'b0, done, ft = 1'b0;
  logic [DCF_WIDTH-1:0] data_in_bus = '0, data_out_bus, word;
  logic empty_indicator_n, full_indicator_n, output_ready_n, input_space_indicator_n;
  logic almost_empty_indicator_n, half_full_indicator_n, almost_full_indicator_n;
  logic [16:0] quota = '0;
  logic pend = 1'b0;
  logic [DCF_WIDTH-1:0] q[$];
  int err_count = 0, samples_checked = 0, cyc = 0, stored = 0, n = 0, m = 0, d = 0;
  dcf_flag_top #(.DEPTH(D)) i_dcf_flag_top (.clk(clk), .nrst(nrst),
    .mode_select_pin(mode_select_pin), .offset_load_select(offset_load_select),
    .write_enable_n(write_enable_n), .data_in_bus(data_in_bus), .read_enable_n(read_enable_n),
    .data_out_bus(data_out_bus), .empty_indicator_n(empty_indicator_n),
    .full_indicator_n(full_indicator_n), .output_ready_n(output_ready_n),
    .input_space_indicator_n(input_space_indicator_n),
    .almost_empty_indicator_n(almost_empty_indicator_n),
    .half_full_indicator_n(half_full_indicator_n),
    .almost_full_indicator_n(almost_full_indicator_n));
  dcf_reader_model i_dcf_reader_model (.clk(clk), .load(load), .quota(quota), .slow(slow),
    .ld(offset_load_select), .word_ready(ft ? !output_ready_n : empty_indicator_n),
    .read_enable_n(read_enable_n), .done(done));
  always #25 clk = ~clk;
  task automatic close_out();
    $display("Checks %0d, errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [DCF_WIDTH-1:0] got, input logic [DCF_WIDTH-1:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 80000) begin
      err_count++;
      close_out();
    end
    pend <= !read_enable_n && ((!offset_load_select && write_enable_n) ||
      (offset_load_select && !ft && empty_indicator_n));
  end
  // Words are compared where they stand, in the order they were written.
  always @(negedge clk) begin
    if (pend || (ft && !read_enable_n && offset_load_select && !output_ready_n)) begin
      word = q.pop_front();
      chk(data_out_bus, word);
    end
  end
  task automatic wr(input int k, input bit keep);
    logic [DCF_WIDTH-1:0] v;
    repeat (k) begin
      @(posedge clk);
      v = 18'h20000 | DCF_WIDTH'($urandom);
      write_enable_n <= 1'b0;
      data_in_bus <= v;
      if (keep) begin
        q.push_back(v);
        stored++;
      end
    end
    @(posedge clk);
    write_enable_n <= 1'b1;
  endtask
  task automatic rd(input int k);
    @(posedge clk);
    quota <= 17'(k);
    load <= 1'b1;
    @(posedge clk);
    load <= 1'b0;
    @(negedge clk);
    while (!done) @(negedge clk);
  endtask
  task automatic flags(input int c);
    logic [4:0] e;
    repeat (10) @(posedge clk);
    @(negedge clk);
    e = {c > n + d, c <= D / 2 + d, c < D + d - m, ft ? c == D + 1 : c != D, ft ? c == 0 : c != 0};
    chk({13'h0, almost_empty_indicator_n, half_full_indicator_n, almost_full_indicator_n,
      ft ? input_space_indicator_n : full_indicator_n,
      ft ? output_ready_n : empty_indicator_n}, {13'h0, e});
  endtask
  task automatic run(input bit fwft, input bit serial);
    int pts[7];
    @(posedge clk);
    nrst <= 1'b0;
    mode_select_pin <= fwft;
    offset_load_select <= serial;
    slow <= serial;
    ft = fwft;
    d = fwft;
    n = int'(serial ? DCF_OFS_SERIAL_DEF : DCF_OFS_PARALLEL_DEF);
    m = n;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    offset_load_select <= 1'b0;
    flags(0);
    q.push_back(DCF_WIDTH'(n));
    q.push_back(DCF_WIDTH'(m));
    rd(2);
    @(posedge clk);
    offset_load_select <= 1'b1;
    wr(1, 1);
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk(data_out_bus, DCF_WIDTH'(m));
    @(negedge clk);
    chk(data_out_bus, ft ? q[0] : DCF_WIDTH'(m));
    pts = '{n, n + 1, D / 2, D / 2 + 1, D - m - 1, D - m, D};
    foreach (pts[i]) begin
      wr(pts[i] + d - stored, 1);
      flags(stored);
    end
    wr(3, 0);
    flags(stored);
    rd(1);
    stored--;
    flags(stored);
    for (int i = 5; i >= 0; i--) begin
      rd(stored - pts[i] - d);
      stored = pts[i] + d;
      flags(stored);
    end
    rd(stored);
    stored = 0;
    flags(0);
    chk(DCF_WIDTH'(q.size()), '0);
  endtask
  initial begin
    void'($urandom(92));
    run(1'b0, 1'b0);
    run(1'b1, 1'b1);
    close_out();
  end
endmodule
